// file: inc/heater_supervisor_map.svh
// Constants: reset values and timing figures of the heater channel supervisor
`ifndef HEATER_SUPERVISOR_MAP_SVH
`define HEATER_SUPERVISOR_MAP_SVH

// ==========================================================
// Clock and timing
`define HS_CLK_HZ          25000000
`define HS_DEBOUNCE_MS     20
`define HS_TEST_TOGGLE_S   5
`define HS_TEST_LEN_S      30

// ==========================================================
// Channel count, per-channel reset values and the device soft-off reset value
`define HS_NUM_CH          7
`define HS_RST_CHECK_EN    1'b0
`define HS_RST_CLOSED_OK   1'b0
`define HS_RST_CHAN_ON     1'b1
`define HS_RST_HEAT_OPEN   1'b0
`define HS_RST_SOFT_OFF    1'b0

`endif

// file: inc/heater_supervisor_pkg.sv
// Types shared by the heater channel supervisor and its bench
`default_nettype none
package heater_supervisor_pkg;

	// Device on/off state, one-hot
	typedef enum logic [2:0] {
		DEV_ON         = 3'b001,
		DEV_OFF_SOFT   = 3'b010,
		DEV_OFF_SWITCH = 3'b100
	} dev_state_e;

	// Per-channel settings
	typedef struct packed {
		logic check_en;
		logic check_closed_ok;
		logic chan_on;
		logic heat_open;
	} chan_cfg_s;

	// Alarm causes of one channel
	typedef struct packed {
		logic present;
		logic cable_fail;
		logic sensor_fail;
	} alarm_cause_s;

endpackage : heater_supervisor_pkg
`default_nettype wire

// file: verilog/contact_debouncer.sv
// Three-flop synchroniser and stability debouncer for one contact input
`default_nettype none
module contact_debouncer #(
	parameter int STABLE_CYCLES = 500000
)(
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic pin,
	output logic      level
);
	logic        s1_reg;
	logic        s2_reg;
	logic        s3_reg;
	logic [31:0] cnt_reg;

	always_ff @(posedge clk)
	begin
		s1_reg <= pin;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
	end

	// ==========================================================
	// A change is accepted only after the contact has held still
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cnt_reg <= 32'h0;
			level   <= 1'b0;
		end
		else if (s2_reg != s3_reg || s3_reg == level)
			cnt_reg <= 32'h0;
		else if (cnt_reg >= 32'(STABLE_CYCLES - 1))
		begin
			cnt_reg <= 32'h0;
			level   <= s3_reg;
		end
		else
			cnt_reg <= cnt_reg + 32'h1;
	end
endmodule : contact_debouncer
`default_nettype wire

// file: verilog/relay_test_timer.sv
// Timed relay exercise for one channel: on/off every step until the test ends
`default_nettype none
`include "heater_supervisor_map.svh"
module relay_test_timer #(
	parameter int TICK_CYCLES = `HS_CLK_HZ
)(
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic start,
	input  wire logic stop,
	input  wire logic allow,
	output logic      running,
	output logic      phase_on
);
	localparam int STEPS = `HS_TEST_LEN_S / `HS_TEST_TOGGLE_S;

	logic [31:0] pre_reg;
	logic [7:0]  sec_reg;
	logic [7:0]  step_reg;
	logic        tick;

	// Prescaler restarts with the test so every step is whole
	assign tick = running && (pre_reg == 32'(TICK_CYCLES - 1));

	always_ff @(posedge clk)
	begin
		if (srst || !running || (start && allow))
			pre_reg <= 32'h0;
		else if (tick)
			pre_reg <= 32'h0;
		else
			pre_reg <= pre_reg + 32'h1;
	end

	always_ff @(posedge clk)
	begin
		if (srst || stop)
		begin
			running  <= 1'b0;
			phase_on <= 1'b0;
			sec_reg  <= 8'h0;
			step_reg <= 8'h0;
		end
		else if (start && allow)
		begin
			running  <= 1'b1;
			phase_on <= 1'b1;
			sec_reg  <= 8'h0;
			step_reg <= 8'h0;
		end
		else if (tick)
		begin
			if (sec_reg == 8'(`HS_TEST_TOGGLE_S - 1))
			begin
				sec_reg <= 8'h0;
				if (step_reg == 8'(STEPS - 1))
				begin
					running  <= 1'b0;
					phase_on <= 1'b0;
				end
				else
				begin
					step_reg <= step_reg + 8'h1;
					phase_on <= ~phase_on;
				end
			end
			else
				sec_reg <= sec_reg + 8'h1;
		end
	end
endmodule : relay_test_timer
`default_nettype wire

// file: verilog/heater_channel_supervisor.sv
// Seven-channel heater supervision: current check, on/off gating, relay test, alarms, counters
//
// Summary of operation
// R1: Check current only while channel heats.
// R2: Failed enabled current check raises channel alarm.
// R3: Per-channel check enable, reset disabled.
// R4: Per-channel polarity: open-ok or closed-ok.
// R5: Polarity resets to open-means-ok.
// R6: Monitor n wired to check input n.
// R7: Monitor contact sense either way round.
// R8: Channel off: no regulation, no alarms, settings kept.
// R9: Off channel still observed and configurable.
// R10: Device off suspends all channels, keeps settings; a relay test still starts and drives its relay.
// R11: Switch input also forces device off.
// R12: No switch attached means device on.
// R13: Report soft off and switch off distinctly.
// R14: Relay test toggles every 5s for 30s.
// R15: Relay test start and stop per channel.
// R16: Alarm relay with NO and NC contacts.
// R17: All channel causes share one alarm flag.
// R18: Device alarm when any channel alarm present.
// R19: Mask alarms of off channel or device.
// R20: Each active alarm individually retrievable.
// R21: Per-channel on counters, total, clearable.
// R22: Heating contact sense per channel, default closed.
// R23: Synchronise and debounce all contact inputs.
`default_nettype none
`include "heater_supervisor_map.svh"
module heater_channel_supervisor
	import heater_supervisor_pkg::*;
#(
	parameter int NUM_CH          = `HS_NUM_CH,
	parameter int CNT_W           = 16,
	parameter int DEBOUNCE_CYCLES = (`HS_CLK_HZ / 1000) * `HS_DEBOUNCE_MS,
	parameter int TICK_CYCLES     = `HS_CLK_HZ
)(
	input  wire logic                        clk,
	input  wire logic                        srst,
	// Contact pins: 1 = shorted to the common return
	input  wire logic [NUM_CH-1:0]           channel_check_inputs,
	input  wire logic                        device_off_switch_input,
	// From regulation and sensing
	input  wire logic [NUM_CH-1:0]           heating_request,
	input  wire logic [NUM_CH-1:0]           sensor_fault,
	input  wire logic [NUM_CH-1:0]           channel_active,
	// Settings
	input  wire logic                        cfg_write,
	input  wire logic [2:0]                  cfg_channel,
	input  wire chan_cfg_s                   cfg_data,
	input  wire logic                        soft_off_write,
	input  wire logic                        soft_off_value,
	// Relay test commands, one-cycle pulses
	input  wire logic [NUM_CH-1:0]           test_start,
	input  wire logic [NUM_CH-1:0]           test_stop,
	// Counter access
	input  wire logic                        counter_clear,
	input  wire logic [2:0]                  view_channel,
	// Outputs
	output logic      [NUM_CH-1:0]           relay_closed,
	output logic      [NUM_CH-1:0]           heating_on,
	output logic      [NUM_CH-1:0]           test_running,
	output logic                             alarm_no_closed,
	output logic                             alarm_nc_closed,
	output logic      [NUM_CH-1:0]           channel_alarm,
	output logic                             device_alarm,
	output alarm_cause_s                     alarm_view,
	output logic      [2:0]                  alarm_next,
	output dev_state_e                       device_state,
	output chan_cfg_s                        cfg_view,
	output logic      [NUM_CH-1:0]           check_ok,
	output logic      [CNT_W-1:0]            count_view,
	output logic      [CNT_W+2:0]            count_total
);
	localparam int TOT_W = CNT_W + 3;

	// ==========================================================
	// Per-channel settings
	chan_cfg_s cfg_reg [NUM_CH];
	logic      soft_off_reg;

	// Settings are taken whatever the channel or device state
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				cfg_reg[i].check_en        <= `HS_RST_CHECK_EN;  // [R3]
				cfg_reg[i].check_closed_ok <= `HS_RST_CLOSED_OK; // [R5]
				cfg_reg[i].chan_on         <= `HS_RST_CHAN_ON;
				cfg_reg[i].heat_open       <= `HS_RST_HEAT_OPEN; // [R22]
			end
		end
		else if (cfg_write && (32'(cfg_channel) < NUM_CH))
			cfg_reg[cfg_channel] <= cfg_data; // [R9]
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			soft_off_reg <= `HS_RST_SOFT_OFF;
		else if (soft_off_write)
			soft_off_reg <= soft_off_value; // [R10]
	end

	// ==========================================================
	// Contact inputs
	logic [NUM_CH-1:0] check_closed;
	logic              switch_closed;

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : g_check_in
			// Monitor n sits on input n
			contact_debouncer #(
				.STABLE_CYCLES (DEBOUNCE_CYCLES)
			) u_deb (
				.clk   (clk),
				.srst  (srst),
				.pin   (channel_check_inputs[g]), // [R6]
				.level (check_closed[g])          // [R23]
			);
		end
	endgenerate

	contact_debouncer #(
		.STABLE_CYCLES (DEBOUNCE_CYCLES)
	) u_switch_deb (
		.clk   (clk),
		.srst  (srst),
		.pin   (device_off_switch_input),
		.level (switch_closed) // [R23]
	);

	// ==========================================================
	// Device on/off state
	// An open switch input, which is what no switch looks like, means on.
	// The switch takes precedence in the report because it cannot be
	// overridden from the menu side.
	always_ff @(posedge clk)
	begin
		if (srst)
			device_state <= DEV_ON;
		else if (switch_closed)
			device_state <= DEV_OFF_SWITCH; // [R11] [R13]
		else if (soft_off_reg)
			device_state <= DEV_OFF_SOFT; // [R13]
		else
			device_state <= DEV_ON; // [R12]
	end

	logic dev_off;
	assign dev_off = (device_state != DEV_ON); // [R10]

	// ==========================================================
	// Relay test and effective heating
	logic [NUM_CH-1:0] test_phase;
	logic [NUM_CH-1:0] chan_on;
	logic [NUM_CH-1:0] heat_next;

	generate
		for (g = 0; g < NUM_CH; g++)
		begin : g_test
			assign chan_on[g] = cfg_reg[g].chan_on;

			relay_test_timer #(
				.TICK_CYCLES (TICK_CYCLES)
			) u_test (
				.clk      (clk),
				.srst     (srst),
				.start    (test_start[g]),    // [R15]
				.stop     (test_stop[g]),     // [R15]
				.allow    (channel_active[g]),
				.running  (test_running[g]),  // [R14]
				.phase_on (test_phase[g])
			);
		end
	endgenerate

	// A running test owns the relay; otherwise regulation drives it only
	// while both the channel and the device are on.
	always_comb
	begin
		for (int i = 0; i < NUM_CH; i++)
		begin
			if (test_running[i])
				heat_next[i] = test_phase[i]; // [R14]
			else
				heat_next[i] = heating_request[i] & chan_on[i] & ~dev_off; // [R8] [R10]
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			heating_on <= '0;
		else
			heating_on <= heat_next;
	end

	// Logical on becomes a closed or an open contact per channel
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			for (int i = 0; i < NUM_CH; i++)
				relay_closed[i] <= `HS_RST_HEAT_OPEN;
		end
		else
		begin
			for (int i = 0; i < NUM_CH; i++)
				relay_closed[i] <= heat_next[i] ^ cfg_reg[i].heat_open; // [R22]
		end
	end

	// ==========================================================
	// Current check
	// The check is only meaningful while current should flow, so a channel
	// with heating off neither passes nor fails.
	logic [NUM_CH-1:0] check_pass;
	logic [NUM_CH-1:0] cable_fail;

	always_comb
	begin
		for (int i = 0; i < NUM_CH; i++)
		begin
			// Either contact sense of the monitor is served by the polarity
			check_pass[i] = cfg_reg[i].check_closed_ok ? check_closed[i]
				: ~check_closed[i]; // [R4] [R7]
			cable_fail[i] = cfg_reg[i].check_en & heating_on[i] & ~check_pass[i]; // [R1] [R2] [R3]
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			check_ok <= '1;
		else
		begin
			for (int i = 0; i < NUM_CH; i++)
				if (heating_on[i] && cfg_reg[i].check_en)
					check_ok[i] <= check_pass[i]; // [R1]
		end
	end

	// ==========================================================
	// Alarms
	logic [NUM_CH-1:0] cable_alarm;
	logic [NUM_CH-1:0] sensor_alarm;
	logic [NUM_CH-1:0] alarm_next_vec;

	always_comb
	begin
		for (int i = 0; i < NUM_CH; i++)
		begin
			cable_alarm[i]    = cable_fail[i] & chan_on[i] & ~dev_off; // [R19] [R8]
			sensor_alarm[i]   = sensor_fault[i] & chan_on[i] & ~dev_off; // [R19]
			alarm_next_vec[i] = cable_alarm[i] | sensor_alarm[i]; // [R17]
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			channel_alarm <= '0;
			device_alarm  <= 1'b0;
		end
		else
		begin
			channel_alarm <= alarm_next_vec;
			device_alarm  <= |alarm_next_vec; // [R18]
		end
	end

	// Alarm relay: NO closes and NC opens on a device alarm
	assign alarm_no_closed = device_alarm;  // [R16]
	assign alarm_nc_closed = ~device_alarm; // [R16]

	// ==========================================================
	// Alarm inspection
	// The viewer picks a channel; alarm_next points to the next channel with
	// an alarm after it, wrapping, so software can step through them all.
	logic [2:0] next_idx;
	logic       found;

	always_comb
	begin
		int j;
		j        = 0;
		next_idx = view_channel;
		found    = 1'b0;
		for (int k = 1; k <= NUM_CH; k++)
		begin
			j = (32'(view_channel) + k) % NUM_CH;
			if (!found && alarm_next_vec[j])
			begin
				next_idx = 3'(j);
				found    = 1'b1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			alarm_view <= '0;
			alarm_next <= 3'h0;
			cfg_view   <= '0;
		end
		else if (32'(view_channel) < NUM_CH)
		begin
			alarm_view.present     <= alarm_next_vec[view_channel]; // [R20]
			alarm_view.cable_fail  <= cable_alarm[view_channel];    // [R20]
			alarm_view.sensor_fail <= sensor_alarm[view_channel];   // [R20]
			alarm_next             <= next_idx;                     // [R20]
			cfg_view               <= cfg_reg[view_channel];        // [R9]
		end
		else
		begin
			alarm_view <= '0;
			alarm_next <= next_idx;
			cfg_view   <= '0;
		end
	end

	// ==========================================================
	// Relay on counters
	// Counters saturate rather than wrap so a worn relay never looks new.
	logic [CNT_W-1:0] count_reg [NUM_CH];
	logic [NUM_CH-1:0] heat_prev_reg;
	logic [TOT_W-1:0]  total_sum;

	always_ff @(posedge clk)
	begin
		if (srst)
			heat_prev_reg <= '0;
		else
			heat_prev_reg <= heating_on;
	end

	always_ff @(posedge clk)
	begin
		if (srst || counter_clear)
		begin
			for (int i = 0; i < NUM_CH; i++)
				count_reg[i] <= '0; // [R21]
		end
		else
		begin
			for (int i = 0; i < NUM_CH; i++)
				if (heating_on[i] && !heat_prev_reg[i] && (count_reg[i] != '1))
					count_reg[i] <= count_reg[i] + CNT_W'(1); // [R21]
		end
	end

	always_comb
	begin
		total_sum = '0;
		for (int i = 0; i < NUM_CH; i++)
			total_sum = total_sum + TOT_W'(count_reg[i]); // [R21]
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			count_view  <= '0;
			count_total <= '0;
		end
		else
		begin
			count_total <= total_sum; // [R21]
			if (32'(view_channel) < NUM_CH)
				count_view <= count_reg[view_channel]; // [R21]
			else
				count_view <= '0;
		end
	end

endmodule : heater_channel_supervisor
`default_nettype wire

// file: tb/current_monitor_model.sv
// Current monitor relays and device off switch seen at the supervisor's contact pins
`default_nettype none
module current_monitor_model
(
	input  wire logic [6:0] heating,
	input  wire logic [6:0] cable_open,
	input  wire logic       sense_flip,
	input  wire logic       switch_closed,
	output logic      [6:0] contact_closed,
	output logic            switch_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Contacts
	// Closed while no current flows, open instead when sense_flip is high; a broken cable never draws current
	assign contact_closed = ~(heating & ~cable_open) ^ {7{sense_flip}};
	// An open or absent switch reads as device on
	assign switch_pin = switch_closed;
endmodule : current_monitor_model
`default_nettype wire

// file: tb/heater_channel_supervisor_assertions.sv
// Port-level checks of the heater channel supervisor
`default_nettype none
module heater_channel_supervisor_assertions
	import heater_supervisor_pkg::*;
#(
	parameter int NUM_CH = 7,
	parameter int CNT_W  = 16
)(
	input wire logic              clk,
	input wire logic              srst,
	input wire logic [NUM_CH-1:0] channel_active,
	input wire logic [NUM_CH-1:0] test_start,
	input wire logic              counter_clear,
	input wire logic [NUM_CH-1:0] heating_on,
	input wire logic [NUM_CH-1:0] test_running,
	input wire logic              alarm_no_closed,
	input wire logic              alarm_nc_closed,
	input wire logic [NUM_CH-1:0] channel_alarm,
	input wire logic              device_alarm,
	input wire dev_state_e        device_state,
	input wire logic [CNT_W+2:0]  count_total
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// ==========
	// Alarms, and heating while the device is off
	property p_dev_alarm;
		device_alarm == (|channel_alarm);
	endproperty
	a_dev_alarm: assert property (p_dev_alarm)
		else $error("device alarm differs from channel alarms");
	property p_contacts;
		alarm_no_closed == device_alarm && alarm_nc_closed == !device_alarm;
	endproperty
	a_contacts: assert property (p_contacts)
		else $error("alarm relay contacts wrong");
	// Channel alarms lag the device state by one cycle, so two cycles are asked for
	property p_off_quiet;
		device_state != DEV_ON && $past(device_state) != DEV_ON |-> channel_alarm == 0;
	endproperty
	a_off_quiet: assert property (p_off_quiet)
		else $error("alarm while device off");
	property p_heat_off;
		device_state != DEV_ON && $past(device_state) != DEV_ON && test_running == 0
			&& $past(test_running) == 0 |-> heating_on == 0;
	endproperty
	a_heat_off: assert property (p_heat_off)
		else $error("heating while device off");
	// ==========
	// Relay test on channel 0, which the bench never stops; refused start on channel 1; counter clear
	sequence s_test_start;
		$rose(test_running[0]);
	endsequence
	property p_test_on;
		s_test_start |-> ##1 heating_on[0] ##50 !heating_on[0];
	endproperty
	a_test_on: assert property (p_test_on)
		else $error("relay test phase timing wrong");
	property p_test_len;
		s_test_start |-> ##299 test_running[0] ##1 !test_running[0];
	endproperty
	a_test_len: assert property (p_test_len)
		else $error("relay test length wrong");
	property p_refuse;
		test_start[1] && !channel_active[1] && !test_running[1] |=> !test_running[1];
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("relay test started on inactive channel");
	property p_count_clear;
		counter_clear [*2] |=> count_total == 0;
	endproperty
	a_count_clear: assert property (p_count_clear)
		else $error("relay counters not cleared");
endmodule : heater_channel_supervisor_assertions
bind heater_channel_supervisor heater_channel_supervisor_assertions
	#(.NUM_CH(NUM_CH), .CNT_W(CNT_W)) u_heater_channel_supervisor_assertions (
	.clk, .srst, .channel_active, .test_start, .counter_clear, .heating_on,
	.test_running, .alarm_no_closed, .alarm_nc_closed, .channel_alarm,
	.device_alarm, .device_state, .count_total);
`default_nettype wire

// file: tb/heater_channel_supervisor_test.sv
// Self-checking bench of the heater channel supervisor
`default_nettype none
module heater_channel_supervisor_test import heater_supervisor_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic         clk = 1'b0, srst = 1'b1, sense = 1'b0, sw = 1'b0, pin_sw, ano, anc, dalm;
	logic         wr = 1'b0, soff_w = 1'b0, soff_v = 1'b0, clr = 1'b0;
	logic [6:0]   hreq = 7'h00, sflt = 7'h00, act = 7'h00, tst = 7'h00, tsp = 7'h00;
	logic [6:0]   brk = 7'h00, pins, relay, heat, run, calm, cok, e, hold;
	logic [2:0]   cch = 3'h0, view = 3'h0, anext;
	chan_cfg_s    cdat = 4'h0, cview, cfgs [7];
	alarm_cause_s aview;
	dev_state_e   dst;
	logic [15:0]  cnt;
	logic [18:0]  tot;
	int           error_cnt = 0, total_checks = 0;
	current_monitor_model u_current_monitor_model (.heating(heat), .cable_open(brk),
		.sense_flip(sense), .switch_closed(sw), .contact_closed(pins), .switch_pin(pin_sw));
	// Short debounce and tick keep the relay test at 300 cycles
	heater_channel_supervisor #(.DEBOUNCE_CYCLES(4), .TICK_CYCLES(10))
	u_heater_channel_supervisor (.clk(clk), .srst(srst), .channel_check_inputs(pins),
		.device_off_switch_input(pin_sw), .heating_request(hreq), .sensor_fault(sflt),
		.channel_active(act), .cfg_write(wr), .cfg_channel(cch), .cfg_data(cdat),
		.soft_off_write(soff_w), .soft_off_value(soff_v), .test_start(tst),
		.test_stop(tsp), .counter_clear(clr), .view_channel(view), .relay_closed(relay),
		.heating_on(heat), .test_running(run), .alarm_no_closed(ano),
		.alarm_nc_closed(anc), .channel_alarm(calm), .device_alarm(dalm),
		.alarm_view(aview), .alarm_next(anext), .device_state(dst), .cfg_view(cview),
		.check_ok(cok), .count_view(cnt), .count_total(tot));
	// ==========
	// Helpers
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic set_cfg(input int ch, input chan_cfg_s d);
		cch = 3'(ch);
		cdat = d;
		wr = 1'b1;
		step(1);
		wr = 1'b0;
		step(1);
	endtask : set_cfg
	task automatic soft_off(input logic v);
		soff_v = v;
		soff_w = 1'b1;
		step(1);
		soff_w = 1'b0;
		step(3);
	endtask : soft_off
	function automatic logic fail_of(input chan_cfg_s c, input logic b);
		return c.check_en & (b ^ sense ^ c.check_closed_ok);
	endfunction : fail_of
	function automatic logic [2:0] nxt(input logic [6:0] a, input logic [2:0] v);
		for (int i = 1; i < 8; i++)
			if (a[(v + i) % 7])
				return 3'((v + i) % 7);
		return v;
	endfunction : nxt
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	initial
	begin
		forever #20 clk = ~clk;
	end
	initial
	begin
		#(40 * 3000);
		error_cnt++;
		test_done();
	end
	// ==========
	// Scenarios
	initial
	begin
		void'($urandom(13));
		step(16);
		srst = 1'b0;
		for (int v = 0; v < 7; v++)
		begin
			view = 3'(v);
			step(2);
			chk(cview, 32'h2);
		end
		chk(dst, DEV_ON);
		chk({anc, ano, cok, relay}, 32'hbf80);
		hreq = 7'h7f;
		set_cfg(3, 4'h3);
		step(3);
		chk({heat, relay}, {7'h7f, 7'h77});
		$display("reset test done");
		for (int k = 0; k < 6; k++)
		begin
			sense = 1'($urandom);
			brk = (k == 0) ? 7'h7f : 7'($urandom);
			for (int c = 0; c < 7; c++)
			begin
				cfgs[c] = {2'($urandom), 2'h2};
				set_cfg(c, cfgs[c]);
				e[c] = fail_of(cfgs[c], brk[c]);
			end
			view = 3'($urandom % 7);
			step(16);
			chk(calm, e);
			chk({dalm, aview.cable_fail}, {|e, e[view]});
			chk(anext, nxt(e, view));
			for (int c = 0; c < 7; c++)
				if (cfgs[c].check_en)
					chk(cok[c], !e[c]);
		end
		hold = cok;
		hreq = 7'h00;
		brk = ~brk;
		step(16);
		chk({cok, calm}, {hold, 7'h00});
		$display("cable test done");
		hreq = 7'h7f;
		for (int c = 0; c < 7; c++)
		begin
			cfgs[c] = {2'b00, 1'($urandom), 1'b0};
			e[c] = cfgs[c].chan_on;
			set_cfg(c, cfgs[c]);
		end
		sflt = 7'($urandom) | 7'h01;
		step(4);
		chk({calm, heat}, {sflt & e, e});
		chk({ano, anc}, {|(sflt & e), ~|(sflt & e)});
		chk(aview, {sflt[view] & e[view], 1'b0, sflt[view] & e[view]});
		soft_off(1'b1);
		set_cfg(0, 4'h1);
		view = 3'h0;
		step(3);
		chk({dst, heat, calm, dalm}, {DEV_OFF_SOFT, 15'h0000});
		chk(cview, 32'h1);
		sw = 1'b1;
		step(12);
		soft_off(1'b0);
		chk(dst, DEV_OFF_SWITCH);
		sw = 1'b0;
		step(12);
		chk(dst, DEV_ON);
		$display("off test done");
		hreq = 7'h00;
		sflt = 7'h00;
		act = 7'h7d;
		clr = 1'b1;
		step(2);
		clr = 1'b0;
		tst = 7'h03;
		step(1);
		tst = 7'h00;
		step(2);
		chk(run, 32'h1);
		step(22);
		chk(heat[0], 32'h1);
		step(50);
		chk(heat[0], 32'h0);
		step(300);
		chk({run, cnt, tot}, {7'h00, 16'h0003, 19'h00003});
		act = 7'h7f;
		tst = 7'h02;
		step(1);
		tst = 7'h00;
		step(5);
		chk(run, 32'h2);
		tsp = 7'h02;
		step(1);
		tsp = 7'h00;
		step(1);
		chk(run, 32'h0);
		$display("relay test done");
		test_done();
	end
endmodule : heater_channel_supervisor_test
`default_nettype wire
